// File: hdl/hpf_host_port.sv
// host register port with interrupt, reset, pause and port a fifo access
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module hpf_host_port import hpf_pkg::*; #(
    parameter int PREFETCH_MAX = PREFETCH_CLK
) (
    input wire logic clock, // 100 MHz
    input wire logic rstn, // hard reset
    input wire logic [ADDR_W-1:0] awaddr, // axi write address
    input wire logic awvalid, // axi
    output logic awready, // axi
    input wire logic [31:0] wdata, // axi
    input wire logic [3:0] wstrb, // axi
    input wire logic wvalid, // axi
    output logic wready, // axi
    output logic [1:0] bresp, // axi
    output logic bvalid, // axi
    input wire logic bready, // axi
    input wire logic [ADDR_W-1:0] araddr, // axi read address
    input wire logic arvalid, // axi
    output logic arready, // axi
    output logic [31:0] rdata, // axi
    output logic [1:0] rresp, // axi
    output logic rvalid, // axi
    input wire logic rready, // axi
    input wire logic busStyleStrap, // byte lane strap, tied
    input wire logic portADmaAck, // port a acknowledge pin
    input wire logic [7:0] coreEvt, // event pulses from the core
    input wire logic coreDone, // end of transfer pulse
    input wire logic lastXferDone, // master pipe drained
    output logic irqOutN, // interrupt request
    output logic waitOutN, // access delayed
    output logic hostFifoSel, // fifo steered to host
    output logic fifoWrValid, // byte to fifo
    output logic [7:0] fifoWrData, // byte to fifo
    input wire logic fifoWrReady, // fifo takes byte
    input wire logic fifoRdValid, // byte from fifo
    input wire logic [7:0] fifoRdData, // byte from fifo
    output logic fifoRdReady, // host takes byte
    output logic [1:0] opMode, // running command family
    output logic cmdStart, // new transfer pulse
    output logic opCancel, // cancel and clear history pulse
    output logic portBReqEn, // master request allowed
    output logic busHiZ, // data buses float
    output logic [7:0] portAConfig // port a configuration
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] stLo_reg, stLo_next, stHi_reg, stHi_next, irqSt_reg, irqSt_next, mask_reg, mask_next;
    logic [7:0] shadow_reg, shadow_next, defer_reg, defer_next, port_a_polarity_reg, port_a_polarity_next, aconf_reg, aconf_next;
    logic [7:0] cmdLo_reg, cmdLo_next, cmdHold_reg, cmdHold_next, dHold_reg, dHold_next;
    logic [15:0] cmd_reg, cmd_next, fData_reg, fData_next, xCnt_reg, xCnt_next;
    logic [1:0] fctl_reg, fctl_next;
    hpf_mode_e mode_reg, mode_next;
    hpf_fx_e fx_reg, fx_next;
    hpf_ps_e ps_reg, ps_next;
    logic [5:0] fetch_reg, fetch_next;
    logic [ADDR_W-1:0] awA_reg, awA_next, arA_reg, arA_next;
    logic [7:0] wD_reg, wD_next, rD_reg, rD_next;
    logic awH_reg, awH_next, wH_reg, wH_next, arH_reg, arH_next, bV_reg, bV_next, rV_reg, rV_next;
    logic start_reg, start_next, cancel_reg, cancel_next, strap_reg;
    logic [2:0] ack_reg;
    logic ackLvl_reg, ackLvl_next;
    logic wrFire, rdFire, byteFire, stall, pauseCmd;
    logic [4:0] wIx, rIx;
    logic [7:0] rVal;

    // strap is static; caught each hard reset so the lane map never moves mid access
    always_ff @(posedge clock) begin
        if (!rstn) begin
            strap_reg <= busStyleStrap;
        end
        ack_reg <= {ack_reg[1:0], portADmaAck};
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign wIx = awA_reg[6:2] ^ {4'h0, strap_reg};
    assign rIx = arA_reg[6:2] ^ {4'h0, strap_reg};
    assign wrFire = awH_reg && wH_reg && !bV_reg;
    assign stall = (rIx == IX_IRQ_ST) && (ps_reg == PS_FETCH);
    assign rdFire = arH_reg && !rV_reg && !stall;
    assign byteFire = (fifoWrValid && fifoWrReady) || (fifoRdValid && fifoRdReady);

    always_comb begin
        unique case (rIx)
            IX_STAT_LO: rVal = stLo_reg;
            IX_STAT_HI: rVal = stHi_reg;
            IX_IRQ_ST: rVal = shadow_reg;
            IX_IRQ_MASK: rVal = mask_reg;
            IX_CMD_LO: rVal = cmd_reg[7:0];
            IX_CMD_HI: rVal = cmd_reg[15:8];
            IX_FDATA_LO: rVal = fData_reg[7:0];
            IX_FDATA_HI: rVal = fData_reg[15:8];
            IX_FCTL: rVal = {6'h00, fctl_reg};
            IX_XCNT_LO: rVal = xCnt_reg[7:0];
            IX_XCNT_HI: rVal = xCnt_reg[15:8];
            IX_ACONF: rVal = aconf_reg;
            IX_PORT_A_POLARITY: rVal = port_a_polarity_reg;
            IX_IDENT: rVal = ID_VALUE;
            default: rVal = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        stLo_next = stLo_reg; stHi_next = stHi_reg; irqSt_next = irqSt_reg; mask_next = mask_reg;
        shadow_next = shadow_reg; defer_next = defer_reg; port_a_polarity_next = port_a_polarity_reg; aconf_next = aconf_reg;
        cmdLo_next = cmdLo_reg; cmdHold_next = cmdHold_reg; dHold_next = dHold_reg; cmd_next = cmd_reg;
        fData_next = fData_reg; xCnt_next = xCnt_reg; fctl_next = fctl_reg; mode_next = mode_reg;
        fx_next = fx_reg; ps_next = ps_reg; fetch_next = fetch_reg; pauseCmd = 1'b0;
        awA_next = awA_reg; arA_next = arA_reg; wD_next = wD_reg; rD_next = rD_reg;
        awH_next = awH_reg; wH_next = wH_reg; arH_next = arH_reg; bV_next = bV_reg; rV_next = rV_reg;
        start_next = 1'b0; cancel_next = 1'b0; cmdHold_next = cmdHold_reg;
        ackLvl_next = (ack_reg[1] == ack_reg[2]) ? ack_reg[2] : ackLvl_reg;
        // bus handshakes
        if (awvalid && !awH_reg) begin
            awA_next = awaddr; awH_next = 1'b1;
        end
        if (wvalid && !wH_reg) begin
            wD_next = wstrb[0] ? wdata[7:0] : 8'h00; wH_next = 1'b1;
        end
        if (bV_reg && bready) bV_next = 1'b0;
        if (rV_reg && rready) rV_next = 1'b0;
        if (arvalid && !arH_reg && !rV_reg) begin
            arA_next = araddr; arH_next = 1'b1;
        end
        if (rdFire) begin
            rD_next = rVal; rV_next = 1'b1; arH_next = 1'b0;
        end
        // host fifo mover: two bytes per request
        if (byteFire) begin
            xCnt_next = xCnt_reg + 16'h0001;
            if (fx_reg == FX_BYTE0) begin
                fx_next = FX_BYTE1;
                if (mode_reg == MODE_DECOMP) fData_next[7:0] = fifoRdData;
            end else begin
                fx_next = FX_IDLE; fctl_next[FCTL_REQ] = 1'b0;
                if (mode_reg == MODE_DECOMP) fData_next[15:8] = fifoRdData;
            end
        end
        // events: status sets whatever the mask, record events deferred when masked
        irqSt_next = irqSt_reg | (coreEvt & ~(mask_reg & IRQ_RECORD_EVT));
        defer_next = defer_reg | (coreEvt & mask_reg & IRQ_RECORD_EVT);
        if (coreDone) begin
            irqSt_next = irqSt_next | defer_reg | (8'h01 << IRQ_DONE);
            defer_next = 8'h00;
            stLo_next[STL_DONE] = 1'b1;
        end
        // pause sequence
        unique case (ps_reg)
            PS_RUN: if ((irqSt_reg & ~mask_reg & IRQ_PAUSE_EVT) != 8'h00) ps_next = PS_BREAK;
            PS_BREAK: if (!ackLvl_reg) begin
                ps_next = PS_FETCH; fetch_next = 6'h00;
            end
            PS_FETCH: begin
                // a read parked on the refresh must not hold the refresh back, or both wait forever
                if (!awH_reg && !(arH_reg && !stall)) fetch_next = fetch_reg + 6'h01;
                if (fetch_reg == 6'(PREFETCH_MAX - 1)) begin
                    ps_next = PS_PAUSED; shadow_next = irqSt_reg; stHi_next[STH_PAUSED] = 1'b1;
                end
            end
            PS_PAUSED: ;
        endcase
        if (ps_reg != PS_FETCH) shadow_next = irqSt_reg;
        // register writes
        if (wrFire) begin
            bV_next = 1'b1; awH_next = 1'b0; wH_next = 1'b0;
            unique case (wIx)
                IX_IRQ_ST: begin
                    // an event landing with the clearing write wins over the clear
                    irqSt_next = (irqSt_reg & wD_reg) | (coreEvt & ~(mask_reg & IRQ_RECORD_EVT));
                    if (coreDone) irqSt_next = irqSt_next | defer_reg | (8'h01 << IRQ_DONE);
                end
                IX_IRQ_MASK: mask_next = wD_reg;
                IX_CMD_LO: cmdHold_next = wD_reg;
                IX_FDATA_LO: dHold_next = wD_reg;
                IX_FDATA_HI: fData_next = {wD_reg, dHold_reg};
                IX_FCTL: begin
                    fctl_next = wD_reg[1:0];
                    // a request is refused while the mover is busy or no command runs
                    if (wD_reg[FCTL_REQ] && wD_reg[FCTL_SEL] && fx_reg == FX_IDLE && mode_reg != MODE_IDLE)
                        fx_next = FX_BYTE0;
                    else
                        fctl_next[FCTL_REQ] = fctl_reg[FCTL_REQ] && !(byteFire && fx_reg == FX_BYTE1);
                end
                IX_ACONF: aconf_next = wD_reg;
                IX_PORT_A_POLARITY: port_a_polarity_next = wD_reg;
                IX_CMD_HI: begin
                    cmd_next = {wD_reg, cmdHold_reg};
                    unique case (cmdHold_reg)
                        OP_COMPRESS, OP_DECOMPRESS: begin
                            // data path and fifo mover left alone
                            mode_next = (cmdHold_reg == OP_COMPRESS) ? MODE_COMP : MODE_DECOMP;
                            start_next = 1'b1; stLo_next = 8'h01 << STL_NEWXFER;
                            if (cmdHold_reg == OP_COMPRESS) irqSt_next = 8'h00;
                        end
                        OP_SOFT_RESET: begin
                            cancel_next = 1'b1;
                            stLo_next = 8'h00; stHi_next = RST_STAT_HI; irqSt_next = 8'h00; mask_next = RST_MASK;
                            shadow_next = 8'h00; defer_next = 8'h00; fData_next = 16'h0000; dHold_next = 8'h00;
                            xCnt_next = 16'h0000; fctl_next = 2'b00; mode_next = MODE_IDLE; fx_next = FX_IDLE;
                            ps_next = PS_RUN;
                        end
                        OP_PAUSE: pauseCmd = 1'b1;
                        OP_RESUME: begin
                            ps_next = PS_RUN; stHi_next[STH_PAUSED] = 1'b0;
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        if (pauseCmd && ps_reg == PS_RUN) ps_next = PS_BREAK;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stLo_reg <= 8'h00; stHi_reg <= RST_STAT_HI; irqSt_reg <= 8'h00; mask_reg <= RST_MASK;
            shadow_reg <= 8'h00; defer_reg <= 8'h00; port_a_polarity_reg <= RST_PORT_A_POLARITY; aconf_reg <= 8'h00;
            cmdLo_reg <= 8'h00; cmdHold_reg <= 8'h00; dHold_reg <= 8'h00; cmd_reg <= 16'h0000;
            fData_reg <= 16'h0000; xCnt_reg <= 16'h0000; fctl_reg <= 2'b00; mode_reg <= MODE_IDLE;
            fx_reg <= FX_IDLE; ps_reg <= PS_RUN; fetch_reg <= 6'h00; ackLvl_reg <= 1'b0;
            awA_reg <= '0; arA_reg <= '0; wD_reg <= 8'h00; rD_reg <= 8'h00;
            awH_reg <= 1'b0; wH_reg <= 1'b0; arH_reg <= 1'b0; bV_reg <= 1'b0; rV_reg <= 1'b0;
            start_reg <= 1'b0; cancel_reg <= 1'b1;
        end else begin
            stLo_reg <= stLo_next; stHi_reg <= stHi_next; irqSt_reg <= irqSt_next; mask_reg <= mask_next;
            shadow_reg <= shadow_next; defer_reg <= defer_next; port_a_polarity_reg <= port_a_polarity_next; aconf_reg <= aconf_next;
            cmdLo_reg <= cmdLo_next; cmdHold_reg <= cmdHold_next; dHold_reg <= dHold_next; cmd_reg <= cmd_next;
            fData_reg <= fData_next; xCnt_reg <= xCnt_next; fctl_reg <= fctl_next; mode_reg <= mode_next;
            fx_reg <= fx_next; ps_reg <= ps_next; fetch_reg <= fetch_next; ackLvl_reg <= ackLvl_next;
            awA_reg <= awA_next; arA_reg <= arA_next; wD_reg <= wD_next; rD_reg <= rD_next;
            awH_reg <= awH_next; wH_reg <= wH_next; arH_reg <= arH_next; bV_reg <= bV_next; rV_reg <= rV_next;
            start_reg <= start_next; cancel_reg <= cancel_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign awready = !awH_reg;
    assign wready = !wH_reg;
    assign bvalid = bV_reg;
    assign bresp = 2'b00;
    assign arready = !arH_reg && !rV_reg;
    assign rvalid = rV_reg;
    assign rresp = 2'b00;
    assign rdata = {24'h000000, rD_reg};
    assign irqOutN = !((irqSt_reg & ~mask_reg) != 8'h00);
    assign waitOutN = !(arH_reg && stall);
    assign hostFifoSel = fctl_reg[FCTL_SEL];
    assign fifoWrValid = hostFifoSel && (mode_reg == MODE_COMP) && (fx_reg != FX_IDLE);
    assign fifoWrData = (fx_reg == FX_BYTE1) ? fData_reg[15:8] : fData_reg[7:0];
    assign fifoRdReady = hostFifoSel && (mode_reg == MODE_DECOMP) && (fx_reg != FX_IDLE);
    assign opMode = mode_reg;
    assign cmdStart = start_reg;
    assign opCancel = cancel_reg;
    assign portBReqEn = (ps_reg == PS_RUN);
    assign busHiZ = (ps_reg == PS_PAUSED) && lastXferDone;
    assign portAConfig = aconf_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_irq_soft_clear;
        @(posedge clock) disable iff (!rstn)
        (wrFire && wIx == IX_CMD_HI && cmdHold_reg == OP_SOFT_RESET) |=> irqOutN && opCancel;
    endproperty
    a_irq_soft_clear: assert property (p_irq_soft_clear) else $error("irq not cleared by soft reset");
    property p_req_two_bytes;
        @(posedge clock) disable iff (!rstn)
        $fell(fctl_reg[FCTL_REQ]) |-> $past(fx_reg) == FX_BYTE1 || $past(wrFire);
    endproperty
    a_req_two_bytes: assert property (p_req_two_bytes) else $error("request cleared early");
    property p_cmd_high_byte;
        @(posedge clock) disable iff (!rstn)
        cmdStart |-> $past(wrFire) && $past(wIx) == IX_CMD_HI;
    endproperty
    a_cmd_high_byte: assert property (p_cmd_high_byte) else $error("command ran without high byte");
    property p_paused_after_fetch;
        @(posedge clock) disable iff (!rstn)
        // soft reset restores the paused bit from its reset value
        $rose(stHi_reg[STH_PAUSED]) && !opCancel |->
            $past(ps_reg) == PS_FETCH && $past(fetch_reg) == 6'(PREFETCH_MAX - 1);
    endproperty
    a_paused_after_fetch: assert property (p_paused_after_fetch) else $error("paused before refresh");
    property p_wait_no_data;
        @(posedge clock) disable iff (!rstn)
        !waitOutN |-> !rvalid ##1 (!waitOutN || rdFire);
    endproperty
    a_wait_no_data: assert property (p_wait_no_data) else $error("wait with data");
    property p_count_step;
        @(posedge clock) disable iff (!rstn)
        (byteFire && !wrFire) |=> xCnt_reg == $past(xCnt_reg) + 16'h0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("transfer count missed a byte");
    property p_dir_by_mode;
        @(posedge clock) disable iff (!rstn)
        (fifoWrValid |-> mode_reg == MODE_COMP) and (fifoRdReady |-> mode_reg == MODE_DECOMP);
    endproperty
    a_dir_by_mode: assert property (p_dir_by_mode) else $error("fifo direction against mode");
    property p_fifo_needs_sel;
        @(posedge clock) disable iff (!rstn)
        (fifoWrValid || fifoRdReady) |-> hostFifoSel;
    endproperty
    a_fifo_needs_sel: assert property (p_fifo_needs_sel) else $error("fifo used without select");
    property p_float_when_paused;
        @(posedge clock) disable iff (!rstn)
        busHiZ |-> stHi_reg[STH_PAUSED] && !portBReqEn;
    endproperty
    a_float_when_paused: assert property (p_float_when_paused) else $error("buses float while running");
    property p_irq_unmasked;
        @(posedge clock) disable iff (!rstn)
        $fell(irqOutN) |-> $past((irqSt_next & ~mask_next) != 8'h00);
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked) else $error("irq without unmasked source");
endmodule : hpf_host_port

// File: hdl/hpf_pkg.sv
// constants and types of the host port with pause and fifo access
// Operation
// - strap high: chip select plus direction; strap low: separate read and write strobes.
// - strap low: address bit 0 low picks low byte; strap high inverts.
// - interrupt output active while any unmasked interrupt status bit is set.
// - interrupts clear on hard reset, soft reset, new compression, or zero write.
// - status sets regardless of mask; masked record and byte events wait for end.
// - hard reset clears every register, cancels operations, clears history buffer; here mask, polarity and high status reset to nonzero values.
// - soft reset keeps config, polarity, identification, command; resets all else.
// - a new transfer command does not reinitialise the data path.
// - access select held during host fifo access; it steers the fifo to host.
// - host fifo request reads in decompression, writes in compression, nothing else.
// - on host fifo read, request clears only after two bytes reach data register.
// - host fifo bytes update transfer count and status like port transfers; here only the transfer count steps.
// - 16-bit register updates after both bytes; command runs on its high byte.
// - pause command or unmasked data transfer interrupt pauses at next handshake break.
// - slave port pauses after its acknowledge drops; master request stays low.
// - once paused and finished, data buses float until a resume command.
// - pause refreshes prefetched registers within forty clocks before paused flag sets.
package hpf_pkg;
    localparam int ADDR_W = 7;
    localparam int PREFETCH_CLK = 40;
    localparam int WRITE_GAP_CLK = 8;
    // register indices, byte address is four times the index
    localparam logic [4:0] IX_STAT_LO = 5'h00;
    localparam logic [4:0] IX_STAT_HI = 5'h01;
    localparam logic [4:0] IX_IRQ_ST = 5'h02;
    localparam logic [4:0] IX_IRQ_MASK = 5'h03;
    localparam logic [4:0] IX_CMD_LO = 5'h04;
    localparam logic [4:0] IX_CMD_HI = 5'h05;
    localparam logic [4:0] IX_FDATA_LO = 5'h06;
    localparam logic [4:0] IX_FDATA_HI = 5'h07;
    localparam logic [4:0] IX_FCTL = 5'h08;
    localparam logic [4:0] IX_XCNT_LO = 5'h0a;
    localparam logic [4:0] IX_XCNT_HI = 5'h0b;
    localparam logic [4:0] IX_ACONF = 5'h0c;
    localparam logic [4:0] IX_PORT_A_POLARITY = 5'h0d;
    localparam logic [4:0] IX_IDENT = 5'h0e;
    // field positions
    localparam int FCTL_SEL = 0;
    localparam int FCTL_REQ = 1;
    localparam int STH_PAUSED = 2;
    localparam int STL_NEWXFER = 7;
    localparam int STL_DONE = 0;
    localparam int IRQ_DONE = 7;
    localparam logic [7:0] IRQ_RECORD_EVT = 8'h1e;
    localparam logic [7:0] IRQ_PAUSE_EVT = 8'h7f;
    // reset values
    localparam logic [7:0] RST_STAT_HI = 8'h0c;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] RST_PORT_A_POLARITY = 8'hff;
    localparam logic [7:0] ID_VALUE = 8'h5a; // arbitrary value
    // command opcodes, carried in the low command byte
    localparam logic [7:0] OP_COMPRESS = 8'h01;
    localparam logic [7:0] OP_DECOMPRESS = 8'h02;
    localparam logic [7:0] OP_SOFT_RESET = 8'h03;
    localparam logic [7:0] OP_PAUSE = 8'h04;
    localparam logic [7:0] OP_RESUME = 8'h05;
    localparam logic [7:0] OP_SELECT_A = 8'h06;
    typedef enum logic [1:0] {MODE_IDLE = 2'b00, MODE_COMP = 2'b01, MODE_DECOMP = 2'b10} hpf_mode_e;
    typedef enum logic [1:0] {FX_IDLE = 2'b00, FX_BYTE0 = 2'b01, FX_BYTE1 = 2'b10} hpf_fx_e;
    typedef enum logic [1:0] {PS_RUN = 2'b00, PS_BREAK = 2'b01, PS_FETCH = 2'b10, PS_PAUSED = 2'b11} hpf_ps_e;
endpackage : hpf_pkg

// File: sim/hpf_fifo_model.sv
// far-side port a fifo model with random stalls
`timescale 1ns/100ps
module hpf_fifo_model (
    input wire logic clock, // bench clock
    input wire logic fifoWrValid, // byte offered
    input wire logic [7:0] fifoWrData, // byte offered
    output logic fifoWrReady, // byte taken
    output logic fifoRdValid, // byte offered to host
    output logic [7:0] fifoRdData, // byte offered to host
    input wire logic fifoRdReady // host takes byte
);
    initial begin
        fifoWrReady = 1'b0;
        fifoRdValid = 1'b0;
        fifoRdData = 8'h00;
    end
    // read bytes count up from zero so the bench knows them; valid holds until taken
    always @(posedge clock) begin
        fifoWrReady <= 1'($urandom_range(1, 0));
        if (!fifoRdValid || fifoRdReady) fifoRdValid <= 1'($urandom_range(1, 0));
        if (fifoRdValid && fifoRdReady) fifoRdData <= fifoRdData + 8'h01;
    end
endmodule : hpf_fifo_model

// File: sim/hpf_host_port_tb_top.sv
// testbench of the host port: register bus, interrupt, fifo write and resets
`timescale 1ns/100ps
module hpf_host_port_tb_top;
    import hpf_pkg::*;
    logic clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, opMode;
    logic irqOutN, hostFifoSel, fifoWrValid, fifoWrReady, fifoRdValid, fifoRdReady, coreDone;
    logic waitOutN, portBReqEn, busHiZ, waitSeen;
    logic [7:0] fifoWrData, fifoRdData, portAConfig, acv, b0, b1;
    logic [7:0] rq[$];
    logic [7:0] fq[$];
    int n_fail = 0;
    int samples_checked = 0;
    hpf_host_port #(.PREFETCH_MAX(16)) u_hpf_host_port (.clock(clock), .rstn(rstn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .busStyleStrap(1'b0),
        .portADmaAck(1'b0), .coreEvt(8'h00), .coreDone(coreDone), .lastXferDone(1'b1), .irqOutN(irqOutN),
        .waitOutN(waitOutN), .hostFifoSel(hostFifoSel), .fifoWrValid(fifoWrValid), .fifoWrData(fifoWrData),
        .fifoWrReady(fifoWrReady), .fifoRdValid(fifoRdValid), .fifoRdData(fifoRdData),
        .fifoRdReady(fifoRdReady), .opMode(opMode), .cmdStart(), .opCancel(), .portBReqEn(portBReqEn),
        .busHiZ(busHiZ),
        .portAConfig(portAConfig));
    hpf_fifo_model u_hpf_fifo_model (.clock(clock), .fifoWrValid(fifoWrValid), .fifoWrData(fifoWrData),
        .fifoWrReady(fifoWrReady), .fifoRdValid(fifoRdValid), .fifoRdData(fifoRdData),
        .fifoRdReady(fifoRdReady));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // --------------------------------
    // bus monitor: releases and compares
    // --------------------------------
    always @(posedge clock) begin
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid && bready) bready <= 1'b0;
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
            rready <= 1'b0;
            chk("read data", rq.pop_front(), rdata[7:0]);
        end
        if (fifoWrValid && fifoWrReady) chk("fifo byte", fq.pop_front(), fifoWrData);
        if (!waitOutN) waitSeen <= 1'b1;
    end
    // spacing keeps same-address writes eight clocks apart
    task automatic wr(input logic [4:0] ix, input logic [7:0] d);
        @(posedge clock);
        awaddr <= {ix, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge clock); while (awvalid || wvalid || bready);
        repeat (8) @(posedge clock);
    endtask : wr
    task automatic rd(input logic [4:0] ix, input logic [7:0] exp);
        @(posedge clock);
        rq.push_back(exp);
        araddr <= {ix, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arvalid || rready);
    endtask : rd
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, coreDone, waitSeen} = '0;
        awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf; rstn = 1'b0;
        void'($urandom(80874));
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        rd(IX_STAT_HI, RST_STAT_HI);
        rd(IX_IRQ_MASK, RST_MASK);
        rd(IX_IDENT, ID_VALUE);
        wr(IX_CMD_LO, OP_COMPRESS);
        chk("mode after low byte", 8'(MODE_IDLE), {6'h0, opMode});
        wr(IX_CMD_HI, 8'h00);
        chk("mode after high byte", 8'(MODE_COMP), {6'h0, opMode});
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        fq.push_back(b0);
        fq.push_back(b1);
        wr(IX_FDATA_LO, b0);
        wr(IX_FDATA_HI, b1);
        wr(IX_FCTL, 8'h03);
        chk("fifo steered", 8'h01, {7'h0, hostFifoSel});
        for (int i = 0; i < 200 && fq.size() > 0; i++) @(posedge clock);
        repeat (4) @(posedge clock);
        rd(IX_FCTL, 8'h01);
        rd(IX_XCNT_LO, 8'h02);
        wr(IX_FCTL, 8'h00);
        wr(IX_IRQ_MASK, 8'h7f);
        @(posedge clock) coreDone <= 1'b1;
        @(posedge clock) coreDone <= 1'b0;
        repeat (2) @(posedge clock);
        chk("irq raised", 8'h00, {7'h0, irqOutN});
        rd(IX_IRQ_ST, 8'h80);
        rd(IX_STAT_LO, 8'h81);
        wr(IX_IRQ_ST, 8'h00);
        chk("irq cleared", 8'h01, {7'h0, irqOutN});
        acv = 8'($urandom);
        wr(IX_ACONF, acv);
        wr(IX_CMD_LO, OP_SOFT_RESET);
        wr(IX_CMD_HI, 8'h00);
        chk("config kept", acv, portAConfig);
        chk("mode cancelled", 8'(MODE_IDLE), {6'h0, opMode});
        rd(IX_IRQ_MASK, RST_MASK);
        rd(IX_XCNT_LO, 8'h00);
        // host read of two fifo bytes in decompression
        wr(IX_CMD_LO, OP_DECOMPRESS);
        wr(IX_CMD_HI, 8'h00);
        wr(IX_FCTL, 8'h03);
        repeat (40) @(posedge clock);
        rd(IX_FCTL, 8'h01);
        rd(IX_FDATA_LO, 8'h00);
        rd(IX_FDATA_HI, 8'h01);
        rd(IX_XCNT_LO, 8'h02);
        // resume clears the reset paused bit, then a pause refreshes and floats the buses
        wr(IX_CMD_LO, OP_RESUME);
        wr(IX_CMD_HI, 8'h00);
        rd(IX_STAT_HI, 8'h08);
        wr(IX_CMD_LO, OP_PAUSE);
        wr(IX_CMD_HI, 8'h00);
        rd(IX_IRQ_ST, 8'h00);
        chk("wait seen", 8'h01, {7'h0, waitSeen});
        rd(IX_STAT_HI, 8'h0c);
        chk("port b request", 8'h00, {7'h0, portBReqEn});
        chk("buses float", 8'h01, {7'h0, busHiZ});
        wr(IX_CMD_LO, OP_RESUME);
        wr(IX_CMD_HI, 8'h00);
        chk("buses driven", 8'h00, {7'h0, busHiZ});
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        test_done();
    end
endmodule : hpf_host_port_tb_top
